//--- rtl/pls_decode.sv
// opcode decoder for the pointer subtract and subtract-return words
`include "pls_defines.svh"
module pls_decode
  import pls_pkg::*;
(
  input  wire logic [15:0] i_word,
  input  wire logic        i_valid,
  output pls_pkg::pls_op_t o_op,
  output logic [1:0]       o_sel,
  output logic [5:0]       o_lit
);
  always_comb begin
    o_sel = i_word[`PLS_SEL_MSB:`PLS_SEL_LSB];
    o_lit = i_word[`PLS_LIT_MSB:`PLS_LIT_LSB];
    o_op  = PLS_OP_NONE;
    // RQ2 upper byte match
    if (i_valid && i_word[15:8] == `PLS_OPC_HI) begin
      // RQ4 selector 11 means return form
      if (o_sel == `PLS_SEL_RETURN) begin
        o_op = PLS_OP_SUBRET;
      end else begin
        o_op = PLS_OP_SUBPTR;
      end
    end
  end
endmodule : pls_decode

//--- rtl/pls_defines.svh
// constants for the pointer literal subtract execution block
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH
`define PLS_OPC_HI        8'hE9
`define PLS_SEL_MSB       7
`define PLS_SEL_LSB       6
`define PLS_LIT_MSB       5
`define PLS_LIT_LSB       0
`define PLS_SEL_RETURN    2'h3
`define PLS_PTR_W         12
`define PLS_PC_W          21
`define PLS_NUM_PTR       3
`define PLS_PTR_RESET     12'h000
`define PLS_PC_RESET      21'h000000
`endif

//--- rtl/pls_exec.sv
// execution of pointer literal subtract and subtract-and-return
// Operation
// RQ1 - subtract literal 0..63 from selected pointer
// RQ2 - opcode E9 byte, one word, one cycle
// RQ3 - return form subtracts literal from third pointer
// RQ4 - selector 11 selects the return form
// RQ5 - then load program counter from stack top
// RQ6 - return takes two cycles, second is no-op
// RQ7 - subtraction wraps, no flag raised
`include "pls_defines.svh"
module pls_exec
  import pls_pkg::*;
(
  input  wire logic                   I_CLK,
  input  wire logic                   I_RESET_N,
  input  wire logic [15:0]            I_WORD,
  input  wire logic                   I_WORD_VALID,
  input  wire logic [`PLS_PC_W-1:0]   I_TOP_OF_RETURN_STACK,
  output logic [`PLS_PTR_W-1:0]       O_PTR0,
  output logic [`PLS_PTR_W-1:0]       O_PTR1,
  output logic [`PLS_PTR_W-1:0]       O_PTR2,
  output logic [`PLS_PC_W-1:0]        O_PC,
  output logic                        O_PC_LOAD,
  output logic                        O_POP,
  output logic                        O_FLUSH,
  output logic                        O_DONE
);
  import pls_pkg::*;

  pls_op_t                    op;
  logic [1:0]                 sel;
  logic [5:0]                 lit;
  pls_state_t                 state;
  logic                       accept;
  logic [`PLS_PTR_W-1:0]      ptr [`PLS_NUM_PTR];
  logic [`PLS_PTR_W-1:0]      next_ptr [`PLS_NUM_PTR];

  pls_decode u_dec (
    .i_word  (I_WORD),
    .i_valid (I_WORD_VALID),
    .o_op    (op),
    .o_sel   (sel),
    .o_lit   (lit)
  );

  // words arriving during the refill cycle are discarded, they are stale prefetch
  assign accept = (state == PLS_ST_EXEC);

  genvar g;
  generate
    for (g = 0; g < `PLS_NUM_PTR; g++) begin : g_ptr
      always_comb begin
        next_ptr[g] = ptr[g];
        // the return form has no pointer of its own and always lands on pointer 2
        // the borrow out of the top bit is dropped, so wrapping costs no extra logic
        // RQ1 RQ3 RQ4 RQ7 wrapping subtract
        if (accept && ((op == PLS_OP_SUBPTR && sel == 2'(g)) ||
                       (op == PLS_OP_SUBRET && g == 2))) begin
          next_ptr[g] = ptr[g] - {{(`PLS_PTR_W-6){1'b0}}, lit};
        end
      end
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          ptr[g] <= `PLS_PTR_RESET;
        end else begin
          ptr[g] <= next_ptr[g];
        end
      end
    end
  endgenerate

  assign O_PTR0 = ptr[0];
  assign O_PTR1 = ptr[1];
  assign O_PTR2 = ptr[2];

  // one flush state is enough: the refill after a return lasts exactly one cycle
  // RQ6 two cycle sequencing
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= PLS_ST_EXEC;
    end else begin
      unique case (state)
        PLS_ST_EXEC: begin
          if (op == PLS_OP_SUBRET) begin
            state <= PLS_ST_FLUSH;
          end
        end
        PLS_ST_FLUSH: begin
          state <= PLS_ST_EXEC;
        end
      endcase
    end
  end

  // O_PC holds between returns; only the load pulse tells the core to take it
  // RQ5 return loads program counter
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PC      <= `PLS_PC_RESET;
      O_PC_LOAD <= 1'b0;
      O_POP     <= 1'b0;
    end else begin
      O_PC_LOAD <= accept && op == PLS_OP_SUBRET;
      O_POP     <= accept && op == PLS_OP_SUBRET;
      if (accept && op == PLS_OP_SUBRET) begin
        O_PC <= I_TOP_OF_RETURN_STACK;
      end
    end
  end

  // RQ2 RQ6 completion pulses
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_FLUSH <= 1'b0;
      O_DONE  <= 1'b0;
    end else begin
      O_FLUSH <= accept && op == PLS_OP_SUBRET;
      O_DONE  <= (accept && op == PLS_OP_SUBPTR) || state == PLS_ST_FLUSH;
    end
  end

  // checks compare against the previous pointer value, so they also catch a subtract in the wrong cycle
  // or on the wrong pointer, except that the pointer 1 check does not look at pointer 2
  property sub_ptr_p;
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (accept && op == PLS_OP_SUBPTR && sel == 2'h0)
      |=> O_PTR0 == $past(O_PTR0) - {6'h00, $past(lit)} &&
          $stable(O_PTR1) && $stable(O_PTR2);
  endproperty
  sub_ptr0_a: assert property (sub_ptr_p) else $error("pointer 0 subtract wrong"); // RQ1

  sub_ptr1_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ7
    (accept && op == PLS_OP_SUBPTR && sel == 2'h1)
      |=> O_PTR1 == $past(O_PTR1) - {6'h00, $past(lit)} && $stable(O_PTR0))
    else $error("pointer 1 subtract wrong");

  sub_ptr2_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ1
    (accept && op == PLS_OP_SUBPTR && sel == 2'h2)
      |=> O_PTR2 == $past(O_PTR2) - {6'h00, $past(lit)} &&
          $stable(O_PTR0) && $stable(O_PTR1))
    else $error("pointer 2 subtract wrong");

  // a wrapped result is always above the old value because the literal is at most 63
  wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ7
    (accept && op == PLS_OP_SUBPTR && sel == 2'h0 && {6'h00, lit} > O_PTR0)
      |=> O_PTR0 > $past(O_PTR0))
    else $error("pointer subtract did not wrap");

  sub_one_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ2
    (accept && op == PLS_OP_SUBPTR) |=> O_DONE && !O_FLUSH && !O_PC_LOAD)
    else $error("pointer subtract not single cycle");

  ret_ptr_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ3
    (accept && op == PLS_OP_SUBRET)
      |=> O_PTR2 == $past(O_PTR2) - {6'h00, $past(lit)} && $stable(O_PTR1))
    else $error("return form pointer update wrong");

  ret_only_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ4
    (accept && op == PLS_OP_SUBRET) |=> $stable(O_PTR0) && $stable(O_PTR1))
    else $error("return form touched pointer 0 or 1");

  ret_sel_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ4
    (I_WORD_VALID && I_WORD[15:8] == 8'hE9 && I_WORD[7:6] == 2'h3) |-> op == PLS_OP_SUBRET)
    else $error("selector 11 not decoded as return");

  ret_pc_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ5
    (accept && op == PLS_OP_SUBRET)
      |=> O_PC_LOAD && O_PC == $past(I_TOP_OF_RETURN_STACK))
    else $error("program counter not loaded from stack top");

  ret_pop_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ5
    (accept && op == PLS_OP_SUBRET) |=> O_POP && O_FLUSH && !O_DONE)
    else $error("return did not pop and flush");

  // the program counter output must not move unless a return is taken
  pc_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ5
    !(accept && op == PLS_OP_SUBRET) |=> $stable(O_PC) && !O_PC_LOAD && !O_POP)
    else $error("program counter moved without return");

  ret_two_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ6
    (accept && op == PLS_OP_SUBRET) |=> !O_DONE ##1 (O_DONE && $stable(O_PTR2)))
    else $error("return not two cycles");

  // the sequencer must fall back on its own, a stuck flush would freeze the core
  ret_state_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ6
    (accept && op == PLS_OP_SUBRET) |=> (state == PLS_ST_FLUSH) ##1 (state == PLS_ST_EXEC))
    else $error("return sequencing wrong");

  // words offered in the refill cycle are stale prefetch and must leave no trace
  refill_ign_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ6
    (state == PLS_ST_FLUSH)
      |=> !O_PC_LOAD && !O_POP && !O_FLUSH &&
          $stable(O_PTR0) && $stable(O_PTR1) && $stable(O_PTR2))
    else $error("word acted on during refill");

  flush_pair_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ6
    O_FLUSH |-> (O_PC_LOAD && O_POP) ##1 (O_DONE && !O_FLUSH))
    else $error("flush not paired with load and done");

  pulse_one_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ6
    O_PC_LOAD |=> !O_PC_LOAD && !O_FLUSH)
    else $error("load pulse longer than one cycle");

  ptr_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ1
    (op == PLS_OP_NONE || !accept)
      |=> $stable(O_PTR0) && $stable(O_PTR1) && $stable(O_PTR2))
    else $error("pointer changed without instruction");

  // any other opcode or a low strobe must look like a plain cycle at the ports
  other_word_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ2
    (state == PLS_ST_EXEC && !(I_WORD_VALID && I_WORD[15:8] == `PLS_OPC_HI))
      |=> !O_DONE && !O_PC_LOAD && !O_FLUSH &&
          $stable(O_PTR0) && $stable(O_PTR1) && $stable(O_PTR2))
    else $error("foreign word changed outputs");

  sub_stay_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N) // RQ4
    (accept && op == PLS_OP_SUBPTR) |=> state == PLS_ST_EXEC && !O_POP)
    else $error("pointer subtract started a return");

  sub_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    accept && op == PLS_OP_SUBPTR && sel == 2'h2);
  wrap_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    accept && op == PLS_OP_SUBPTR && {6'h00, lit} > O_PTR0 && sel == 2'h0);
  ret_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (accept && op == PLS_OP_SUBRET) ##2 (accept && op == PLS_OP_SUBRET));
  order_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (accept && op == PLS_OP_SUBRET) ##2 (accept && op == PLS_OP_SUBPTR));
endmodule : pls_exec

//--- rtl/pls_pkg.sv
// types for the pointer literal subtract execution block
package pls_pkg;
  typedef enum logic [1:0] {
    PLS_OP_NONE   = 2'b00,
    PLS_OP_SUBPTR = 2'b01,
    PLS_OP_SUBRET = 2'b10
  } pls_op_t;
  typedef enum logic [0:0] {
    PLS_ST_EXEC  = 1'b0,
    PLS_ST_FLUSH = 1'b1
  } pls_state_t;
endpackage : pls_pkg

//--- sim/tb.sv
// self-checking bench for the pointer literal subtract execution block
`include "pls_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk;
  logic                  rst_n;
  logic [15:0]           word;
  logic                  valid;
  logic [`PLS_PC_W-1:0]  stack_top;
  logic [`PLS_PTR_W-1:0] ptr [3];
  logic [`PLS_PTR_W-1:0] exp_ptr [3];
  logic [`PLS_PC_W-1:0]  pc;
  logic                  pc_load;
  logic                  pop;
  logic                  flush;
  logic                  done;
  int                    bad_count;
  int                    compares;

  pls_exec dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_WORD(word), .I_WORD_VALID(valid),
    .I_TOP_OF_RETURN_STACK(stack_top), .O_PTR0(ptr[0]), .O_PTR1(ptr[1]), .O_PTR2(ptr[2]),
    .O_PC(pc), .O_PC_LOAD(pc_load), .O_POP(pop), .O_FLUSH(flush), .O_DONE(done));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict;
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // caller lowers valid; back-to-back words keep it high
  task automatic put(input logic [15:0] w);
    word = w;
    valid = 1'b1;
    @(posedge clk);
    #1;
  endtask : put

  task automatic chk_ptrs;
    for (int i = 0; i < 3; i++) check(ptr[i], exp_ptr[i]);
  endtask : chk_ptrs

  // selectors 0 to 2, boundary literals, wrap below zero
  task automatic sub_all;
    logic [5:0] lits [3];
    lits = '{6'h00, 6'h3F, 6'h23};
    for (int f = 0; f < 3; f++) begin
      for (int k = 0; k < 3; k++) begin
        put({8'hE9, 2'(f), lits[k]});
        exp_ptr[f] = exp_ptr[f] - {6'h00, lits[k]};
        chk_ptrs();
        check(done, 1'b1);
        check(pc_load, 1'b0);
      end
    end
    valid = 1'b0;
    @(posedge clk);
    #1;
    check(done, 1'b0);
  endtask : sub_all

  // return form, with a word offered in the refill cycle
  task automatic sub_ret(input logic [`PLS_PC_W-1:0] top, input logic [5:0] lit);
    stack_top = top;
    put({8'hE9, 2'b11, lit});
    word = {8'hE9, 2'b00, 6'h01};
    exp_ptr[2] = exp_ptr[2] - {6'h00, lit};
    chk_ptrs();
    check(pc, top);
    check({pc_load, pop, flush, done}, 4'hE);
    @(posedge clk);
    #1;
    valid = 1'b0;
    check({pc_load, pop, flush, done}, 4'h1);
    chk_ptrs();
    @(posedge clk);
    #1;
    check(done, 1'b0);
    chk_ptrs();
  endtask : sub_ret

  // foreign opcodes and an invalid strobe leave everything alone
  task automatic ignored;
    put(16'hE8C5);
    check({pc_load, done}, 2'h0);
    put(16'h69C5);
    check({pc_load, done}, 2'h0);
    chk_ptrs();
    word = 16'hE9C5;
    valid = 1'b0;
    @(posedge clk);
    #1;
    check({pc_load, done}, 2'h0);
    chk_ptrs();
  endtask : ignored

  // reset in mid-run clears everything at once, then a word is taken straight away
  task automatic mid_reset;
    rst_n = 1'b0;
    exp_ptr = '{default: '0};
    #1;
    chk_ptrs();
    check({pc, pc_load, pop, flush, done}, 25'h0);
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    put({8'hE9, 2'h1, 6'h05});
    exp_ptr[1] = exp_ptr[1] - 12'h005;
    chk_ptrs();
    check(done, 1'b1);
    valid = 1'b0;
    @(posedge clk);
    #1;
    check(done, 1'b0);
  endtask : mid_reset

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #(8 * 500);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    word = 16'h0000;
    valid = 1'b0;
    stack_top = '0;
    bad_count = 0;
    compares = 0;
    exp_ptr = '{default: '0};
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_ptrs();
    check({pc, pc_load, pop, flush, done}, 25'h0);
    sub_all();
    sub_ret(21'h1ABCD5, 6'h23);
    mid_reset();
    ignored();
    sub_ret(21'h0F00A3, 6'h3F);
    give_verdict();
  end
endmodule : tb
